// ---- nfc_cyc_engine.sv ----
// One flash bus cycle: a write strobe or a read strobe.
// Assumes the port input is already synchronised by the top.
`timescale 1ns/10ps
module nfc_cyc_engine
  import nfc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Request side
  nfc_cyc_if.eng          cyc,
  // Pin side
  input  wire logic [7:0] i_io_sync,
  output logic            o_we_n,
  output logic            o_re_n,
  output logic            o_cle,
  output logic            o_ale,
  output logic [7:0]      o_io,
  output logic            o_io_oe
);
  // ==========================================================
  // Phase machine
  typedef enum logic [1:0] {
    NFC_E_IDLE = 2'b00,
    NFC_E_LOW  = 2'b01,
    NFC_E_HIGH = 2'b11
  } nfc_eng_e;
  nfc_eng_e  st_q;
  logic [3:0] cnt_q;
  logic      rd_q;

  // Each strobe is held low then high for a full phase
  always_ff @(posedge i_clk) begin
    cyc.done <= 1'b0;
    if (i_rst) begin
      st_q <= NFC_E_IDLE;
      cnt_q <= 4'h0;
      rd_q <= 1'b0;
      o_we_n <= 1'b1;
      o_re_n <= 1'b1;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_io <= 8'h00;
      o_io_oe <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      unique case (st_q)
        NFC_E_IDLE: begin
          if (cyc.req) begin
            rd_q <= (cyc.kind == NFC_K_RD);
            o_cle <= (cyc.kind == NFC_K_CMD);
            o_ale <= (cyc.kind == NFC_K_ADDR);
            o_io <= cyc.wdata;
            o_io_oe <= (cyc.kind != NFC_K_RD);
            // Falling read strobe fetches next byte
            o_we_n <= (cyc.kind == NFC_K_RD);
            o_re_n <= (cyc.kind != NFC_K_RD);
            cnt_q <= 4'h0;
            st_q <= NFC_E_LOW;
          end
        end
        NFC_E_LOW: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == NFC_PHASE_LAST) begin
            // Rising write strobe latches the byte
            o_we_n <= 1'b1;
            o_re_n <= 1'b1;
            cnt_q <= 4'h0;
            st_q <= NFC_E_HIGH;
          end
        end
        NFC_E_HIGH: begin
          cnt_q <= cnt_q + 4'h1;
          // Latches stay put through the hold phase
          if (cnt_q == NFC_PHASE_LAST) begin
            // Port byte has crossed all three stages only by now
            if (rd_q) cyc.rdata <= i_io_sync;
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_io_oe <= 1'b0;
            cyc.done <= 1'b1;
            st_q <= NFC_E_IDLE;
          end
        end
        default: st_q <= NFC_E_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  AST_WE_RISE_HOLDS: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_we_n) |-> o_io_oe && $stable(o_io))
    else $error("write strobe rose without driven port");
  AST_ONE_LATCH: assert property (@(posedge i_clk) disable iff (i_rst)
    !(o_cle && o_ale))
    else $error("command and address latch both high");
endmodule

// ---- nfc_cyc_if.sv ----
// Interface between the sequencer and its bus-cycle engine.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface nfc_cyc_if;
  import nfc_pkg::*;
  logic      req;
  nfc_kind_e kind;
  logic [7:0] wdata;
  logic      done;
  logic [7:0] rdata;
  modport seq (output req, output kind, output wdata,
               input done, input rdata);
  modport eng (input req, input kind, input wdata,
               output done, output rdata);
endinterface

// ---- nfc_flash_model.sv ----
// Behavioural flash device facing the host sequencer.
// Assumes the bench resolves the shared byte port from the host enable.
`timescale 1ns/10ps
module nfc_flash_model #(
  parameter int         BUSY_NS = 4000,
  parameter int         LOAD_NS = 300,
  parameter logic [7:0] STAT_V  = 8'hC0  // Arbitrary status byte
) (
  // Strobes from the host
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_read_strobe_n,
  input  wire logic       i_spare_area_select_n,
  input  wire logic       i_wp_n,
  // Byte port and status
  input  wire logic [7:0] i_io,
  output logic [7:0]      o_io,
  output logic            o_ready_busy
);
  // ==========================================================
  // One page register and a log of captured bytes
  logic [7:0] page_q [0:527];
  logic [7:0] ev_byte [0:63];
  logic [1:0] ev_kind [0:63];
  logic       ev_se [0:63];
  logic [9:0] col_q;
  logic [7:0] cmd_q;
  logic [7:0] dout_q;
  logic       half_q;
  int         n_ev;
  int         n_busy_cmd;
  int         n_runs;
  int         n_addr;
  initial begin
    for (int i = 0; i < 528; i++)
      page_q[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    n_ev = 0;
    n_busy_cmd = 0;
    n_runs = 0;
    n_addr = 0;
    half_q = 1'b0;
    dout_q = 8'h00;
    o_ready_busy = 1'b1;
  end
  // Chip select is not looked at once busy starts
  task automatic run_busy(input int ns);
    fork
      begin
        o_ready_busy = 1'b0;
        #(ns);
        o_ready_busy = 1'b1;
      end
    join_none
  endtask
  // ==========================================================
  // Capture on write strobe rise
  always @(posedge i_we_n) begin
    if (!i_ce_n) begin
      ev_byte[n_ev] = i_io;
      ev_kind[n_ev] = i_cle ? 2'h0 : (i_ale ? 2'h1 : 2'h2);
      ev_se[n_ev] = i_spare_area_select_n;
      n_ev++;
      if (i_cle) begin
        if (!o_ready_busy)
          n_busy_cmd++;
        cmd_q = i_io;
        half_q = (i_io == 8'h01);
        n_addr = 0;
        if ((i_io == 8'h10 || i_io == 8'hD0) && i_wp_n) begin
          n_runs++;
          run_busy(BUSY_NS);
        end
      end else if (i_ale) begin
        if (n_addr == 0 && cmd_q != 8'h60)
          col_q = (cmd_q == 8'h50) ? {6'h20, i_io[3:0]}
                                   : {1'b0, half_q, i_io};
        n_addr++;
        if (n_addr == 3 && cmd_q inside {8'h00, 8'h01, 8'h50})
          run_busy(LOAD_NS);
      end else begin
        page_q[col_q] = i_io;
        col_q++;
      end
    end
  end
  // Each read strobe fall moves the column on, except after status 70h
  always @(negedge i_read_strobe_n) begin
    if (!i_ce_n) begin
      dout_q = (cmd_q == 8'h70) ? STAT_V : page_q[col_q];
      if (cmd_q != 8'h70)
        col_q++;
    end
  end
  // Released port shows the inverse so stale data never passes
  assign o_io = (!i_ce_n && !i_read_strobe_n) ? dout_q : ~dout_q;
endmodule

// ---- nfc_host.sv ----
// Host-side sequencer for an 8-bit NAND flash command/address port.
// Assumes flash pins wired directly; the ready/busy and port inputs
// are asynchronous to i_clk.
`timescale 1ns/10ps
// Contract
// - Every byte is latched by the flash on write strobe rise, select low.
// - Command latch marks opcodes, address latch marks address bytes.
// - Erase is 60h, block address, then D0h; others one cycle.
// - Read/program address: column, low row, high row bytes.
// - Erase sends only the two row address bytes.
// - Spare read 50h only with spare select held low.
// - While busy only reset and read status may be issued.
module nfc_host
  import nfc_pkg::*;
#(
  parameter int ADDR_W = NFC_ADDR_W
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Operation request
  input  wire logic              i_op_valid,
  input  wire logic [7:0]        i_op_code,
  input  wire logic [ADDR_W-1:0] i_op_addr,
  input  wire logic              i_op_spare,
  input  wire logic              i_op_wp_n,
  output logic                   o_op_ready,
  // Data streams
  input  wire logic              i_wr_valid,
  input  wire logic [7:0]        i_wr_data,
  input  wire logic              i_wr_last,
  output logic                   o_wr_ready,
  input  wire logic              i_rd_req,
  output logic                   o_rd_valid,
  output logic [7:0]             o_rd_data,
  input  wire logic              i_end,
  output logic                   o_busy,
  // Flash pins
  output logic                   o_ce_n,
  output logic                   o_cle,
  output logic                   o_ale,
  output logic                   o_we_n,
  output logic                   o_read_strobe_n,
  output logic                   o_spare_area_select_n,
  output logic                   o_wp_n,
  input  wire logic [7:0]        i_io,
  output logic [7:0]             o_io,
  output logic                   o_io_oe,
  input  wire logic              i_ready_busy
);
  // ==========================================================
  // Input synchronisers
  logic [2:0] rb_sync_q;
  logic [7:0] io_s1_q, io_s2_q, io_s3_q;
  logic       rb_q;
  // A ready/busy change counts once the second and third stages agree; port bytes just pass three stages
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rb_sync_q <= 3'h7;
      rb_q <= 1'b1;
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      io_s3_q <= 8'h00;
    end else begin
      rb_sync_q <= {rb_sync_q[1:0], i_ready_busy};
      if (rb_sync_q[1] == rb_sync_q[2]) rb_q <= rb_sync_q[2];
      io_s1_q <= i_io;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
    end
  end

  // ==========================================================
  // Sequencer
  typedef enum logic [2:0] {
    NFC_S_IDLE  = 3'b000,
    NFC_S_CMD   = 3'b001,
    NFC_S_ADDR  = 3'b011,
    NFC_S_DATA  = 3'b010,
    NFC_S_CMD2  = 3'b110,
    NFC_S_WAIT  = 3'b111,
    NFC_S_DRAIN = 3'b101
  } nfc_seq_e;
  nfc_seq_e         st_q;
  logic [7:0]       op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [1:0]       acnt_q;
  logic             inflight_q;
  logic             wait_q;
  logic             lastwr_q;
  nfc_cyc_if        cyc ();

  logic op_is_read, op_is_erase, op_ok_busy, op_multi;
  assign op_is_read  = (op_q == NFC_OP_READ_A) || (op_q == NFC_OP_READ_B)
                       || (op_q == NFC_OP_READ_SP) || (op_q == NFC_OP_READ_ID)
                       || (op_q == NFC_OP_STATUS);
  assign op_is_erase = (op_q == NFC_OP_ERASE);
  assign op_multi    = op_is_erase || (op_q == NFC_OP_SEQ_IN)
                       || (op_q == NFC_OP_READ_A) || (op_q == NFC_OP_READ_B)
                       || (op_q == NFC_OP_READ_SP);
  // Only reset and status are legal while the flash is busy
  assign op_ok_busy  = (i_op_code == NFC_OP_RESET)
                       || (i_op_code == NFC_OP_STATUS);

  // Read data leaves the engine onto the stream through one register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      o_rd_valid <= cyc.done && cyc.kind == NFC_K_RD;
      if (cyc.done) o_rd_data <= cyc.rdata;
    end
  end

  always_ff @(posedge i_clk) begin
    cyc.req <= 1'b0;
    o_wr_ready <= 1'b0;
    if (i_rst) begin
      st_q <= NFC_S_IDLE;
      op_q <= 8'h00;
      addr_q <= '0;
      acnt_q <= 2'h0;
      inflight_q <= 1'b0;
      wait_q <= 1'b0;
      lastwr_q <= 1'b0;
      o_op_ready <= 1'b0;
      o_busy <= 1'b0;
      o_ce_n <= 1'b1;
      o_spare_area_select_n <= 1'b1;
      o_wp_n <= 1'b0;
      cyc.kind <= NFC_K_CMD;
      cyc.wdata <= 8'h00;
    end else begin
      if (cyc.done) inflight_q <= 1'b0;
      o_op_ready <= 1'b0;
      unique case (st_q)
        NFC_S_IDLE: begin
          o_busy <= !rb_q;
          o_op_ready <= 1'b1;
          if (i_op_valid && o_op_ready && (rb_q || op_ok_busy)) begin
            op_q <= i_op_code;
            addr_q <= i_op_addr;
            // Low protect level blocks array changes
            o_wp_n <= i_op_wp_n;
            // Spare read needs select low; else follow request
            o_spare_area_select_n <= (i_op_code == NFC_OP_READ_SP) ? 1'b0
                                     : !i_op_spare;
            o_ce_n <= 1'b0;
            o_op_ready <= 1'b0;
            o_busy <= 1'b1;
            st_q <= NFC_S_CMD;
          end
        end
        NFC_S_CMD: begin
          if (!inflight_q && !cyc.req) begin
            cyc.kind <= NFC_K_CMD;
            cyc.wdata <= op_q;
            cyc.req <= 1'b1;
            inflight_q <= 1'b1;
            // Erase skips the column byte
            acnt_q <= op_is_erase ? 2'h1 : 2'h0;
            st_q <= op_multi ? NFC_S_ADDR
                  : (op_is_read ? NFC_S_DATA : NFC_S_WAIT);
            wait_q <= (op_q == NFC_OP_PROG) || (op_q == NFC_OP_RESET);
          end
        end
        NFC_S_ADDR: begin
          if (!inflight_q && !cyc.req) begin
            cyc.kind <= NFC_K_ADDR;
            // Column, low row, high row; bit 8 is never sent
            unique case (acnt_q)
              2'h0: cyc.wdata <= addr_q[7:0];
              2'h1: cyc.wdata <= addr_q[NFC_ROW_LO +: 8];
              default: cyc.wdata <= {2'b00,
                         addr_q[NFC_ROW_LO+8 +: NFC_ROW_HI_W]};
            endcase
            cyc.req <= 1'b1;
            inflight_q <= 1'b1;
            acnt_q <= acnt_q + 2'h1;
            if (acnt_q == 2'h2) begin
              // Erase confirms with a second opcode
              st_q <= op_is_erase ? NFC_S_CMD2 : NFC_S_DATA;
              wait_q <= op_q != NFC_OP_SEQ_IN;
            end
          end
        end
        NFC_S_CMD2: begin
          if (!inflight_q && !cyc.req) begin
            cyc.kind <= NFC_K_CMD;
            cyc.wdata <= NFC_OP_ERASE_GO;
            cyc.req <= 1'b1;
            inflight_q <= 1'b1;
            wait_q <= 1'b1;
            st_q <= NFC_S_WAIT;
          end
        end
        NFC_S_DATA: begin
          // Page load of a read must finish before data
          if (!inflight_q && !cyc.req && (rb_q || !wait_q)) begin
            if (op_q == NFC_OP_SEQ_IN) begin
              o_wr_ready <= !o_wr_ready && !lastwr_q;
              if (lastwr_q) begin
                lastwr_q <= 1'b0;
                st_q <= NFC_S_DRAIN;
              end else if (i_wr_valid && o_wr_ready) begin
                cyc.kind <= NFC_K_WR;
                cyc.wdata <= i_wr_data;
                cyc.req <= 1'b1;
                inflight_q <= 1'b1;
                lastwr_q <= i_wr_last;
              end
            end else if (i_end) begin
              st_q <= NFC_S_DRAIN;
            end else if (i_rd_req) begin
              cyc.kind <= NFC_K_RD;
              cyc.req <= 1'b1;
              inflight_q <= 1'b1;
            end
          end
        end
        NFC_S_WAIT: begin
          // Program and erase run inside the flash
          if (!inflight_q && !cyc.req) st_q <= NFC_S_DRAIN;
        end
        NFC_S_DRAIN: begin
          // Hold select low until the flash is ready again when wait_q is set; otherwise release at once
          if (rb_q || !wait_q) begin
            o_ce_n <= 1'b1;
            o_busy <= 1'b0;
            wait_q <= 1'b0;
            st_q <= NFC_S_IDLE;
          end
        end
        default: st_q <= NFC_S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Bus cycle engine
  nfc_cyc_engine u_eng (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .cyc       (cyc.eng),
    .i_io_sync (io_s3_q),
    .o_we_n    (o_we_n),
    .o_re_n    (o_read_strobe_n),
    .o_cle     (o_cle),
    .o_ale     (o_ale),
    .o_io      (o_io),
    .o_io_oe   (o_io_oe)
  );

  // ==========================================================
  // Checks
  AST_BUSY_ONLY_SAFE: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == NFC_S_IDLE && i_op_valid && o_op_ready && !rb_q) |=>
    (op_q == NFC_OP_RESET || op_q == NFC_OP_STATUS))
    else $error("unsafe opcode accepted while busy");
  AST_SPARE_SEL_LOW: assert property (@(posedge i_clk) disable iff (i_rst)
    (cyc.req && cyc.kind == NFC_K_CMD && cyc.wdata == NFC_OP_READ_SP)
    |-> !o_spare_area_select_n)
    else $error("spare read issued with spare select high");
  AST_CE_DURING_OP: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_we_n |-> !o_ce_n)
    else $error("write strobe low with chip deselected");
  AST_ERASE_CONFIRM: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == NFC_S_WAIT && cyc.req && op_is_erase)
    |-> cyc.wdata == NFC_OP_ERASE_GO)
    else $error("erase confirm opcode wrong");
  AST_ERASE_NO_COL: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == NFC_S_ADDR && cyc.req && cyc.kind == NFC_K_CMD && op_is_erase)
    |-> acnt_q == 2'h1)
    else $error("erase would send a column byte");
endmodule

// ---- nfc_pkg.sv ----
// Package of the host-side NAND command/address sequencer.
// Assumes a 40 MHz clock and an 8-bit multiplexed flash port.
package nfc_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] NFC_OP_READ_A   = 8'h00;
  localparam logic [7:0] NFC_OP_READ_B   = 8'h01;
  localparam logic [7:0] NFC_OP_READ_SP  = 8'h50;
  localparam logic [7:0] NFC_OP_SEQ_IN   = 8'h80;
  localparam logic [7:0] NFC_OP_PROG     = 8'h10;
  localparam logic [7:0] NFC_OP_READ_ID  = 8'h90;
  localparam logic [7:0] NFC_OP_RESET    = 8'hFF;
  localparam logic [7:0] NFC_OP_ERASE    = 8'h60;
  localparam logic [7:0] NFC_OP_ERASE_GO = 8'hD0;
  localparam logic [7:0] NFC_OP_STATUS   = 8'h70;
  // ==========================================================
  // Geometry and address layout
  localparam int NFC_ADDR_W    = 23;
  localparam int NFC_PAGE_LEN  = 528;
  localparam int NFC_SPARE_COL = 512;
  localparam int NFC_ROW_LO    = 9;   // First row bit in byte address
  localparam int NFC_ROW_HI_W  = 6;   // Used bits of third cycle
  // ==========================================================
  // Strobe timing
  localparam int NFC_CLK_MHZ   = 40;
  localparam int NFC_PHASE_NS  = 50;  // Low and high phase of a strobe
  localparam int NFC_PHASE_CYC =
    (NFC_PHASE_NS * NFC_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] NFC_PHASE_LAST = 4'(NFC_PHASE_CYC - 1);
  // ==========================================================
  // Request kinds
  typedef enum logic [2:0] {
    NFC_K_CMD  = 3'h0,
    NFC_K_ADDR = 3'h1,
    NFC_K_WR   = 3'h2,
    NFC_K_RD   = 3'h3
  } nfc_kind_e;
endpackage

// ---- tb_top.sv ----
// Self-checking bench of the host sequencer against a flash model.
// Assumes the model logs every byte it captures.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
  import nfc_pkg::*;
  // ==========================================================
  // Signals
  logic        clk, rst, op_valid, op_spare, op_wp_n, op_ready;
  logic        wr_valid, wr_last, wr_ready, rd_req, rd_valid, op_end, busy;
  logic        ce_n, cle, ale, we_n, re_n, se_n, wp_n, io_oe, rb;
  logic [7:0]  op_code, wr_data, rd_data, host_io, dev_io, bus;
  logic [22:0] op_addr;
  int          mismatches;
  int          n_tests;
  localparam logic [22:0] A1 = 23'h4DB110;
  localparam logic [22:0] A2 = 23'h12A340;
  nfc_host nfc_host_inst (.i_clk(clk), .i_rst(rst), .i_op_valid(op_valid),
    .i_op_code(op_code), .i_op_addr(op_addr), .i_op_spare(op_spare),
    .i_op_wp_n(op_wp_n), .o_op_ready(op_ready), .i_wr_valid(wr_valid),
    .i_wr_data(wr_data), .i_wr_last(wr_last), .o_wr_ready(wr_ready),
    .i_rd_req(rd_req), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .i_end(op_end), .o_busy(busy), .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale),
    .o_we_n(we_n), .o_read_strobe_n(re_n), .o_spare_area_select_n(se_n),
    .o_wp_n(wp_n), .i_io(bus), .o_io(host_io), .o_io_oe(io_oe),
    .i_ready_busy(rb));
  nfc_flash_model nfc_flash_model_inst (.i_ce_n(ce_n), .i_cle(cle),
    .i_ale(ale), .i_we_n(we_n), .i_read_strobe_n(re_n),
    .i_spare_area_select_n(se_n), .i_wp_n(wp_n), .i_io(bus),
    .o_io(dev_io), .o_ready_busy(rb));
  // Port level comes from whichever side drives it
  assign bus = io_oe ? host_io : dev_io;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait; an exhausted bound ends the run
  task automatic wait_hi(ref logic s, input logic v, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      if (s === v)
        return;
    end
    mismatches++;
    print_verdict();
  endtask
  task automatic start_op(input logic [7:0] c, input logic [22:0] a,
                          input logic sp);
    op_code = c;
    op_addr = a;
    op_spare = sp;
    op_valid = 1'b1;
    wait_hi(busy, 1'b1, 400);
    op_valid = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, input logic last);
    wr_valid = 1'b1;
    wr_data = d;
    wr_last = last;
    wait_hi(wr_ready, 1'b1, 400);
    @(posedge clk);
    #1;
  endtask
  task automatic rd_byte(input logic [7:0] e);
    rd_req = 1'b1;
    wait_hi(rd_valid, 1'b1, 400);
    `CHK(rd_data, e)
  endtask
  task automatic end_rd();
    op_end = 1'b1;
    wait_hi(busy, 1'b0, 2000);
    op_end = 1'b0;
  endtask
  task automatic chk_ev(input int i, input logic [1:0] k, logic [7:0] v);
    `CHK(nfc_flash_model_inst.ev_kind[i], k)
    `CHK(nfc_flash_model_inst.ev_byte[i], v)
  endtask
  function automatic logic [7:0] pg(input int c);
    return 8'(c) ^ 8'(c >> 8) ^ 8'h5A;
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_read(input logic [7:0] c, input logic [22:0] a,
                        input logic sp, input logic [7:0] e0, e1);
    int b;
    b = nfc_flash_model_inst.n_ev;
    start_op(c, a, sp);
    rd_byte(e0);
    rd_byte(e1);
    rd_req = 1'b0;
    end_rd();
    chk_ev(b, 2'h0, c);
    chk_ev(b + 1, 2'h1, a[7:0]);
    chk_ev(b + 2, 2'h1, a[16:9]);
    chk_ev(b + 3, 2'h1, {2'b00, a[22:17]});
    `CHK(nfc_flash_model_inst.ev_se[b], ~sp)
  endtask
  task automatic t_prog();
    int   b;
    int   nb;
    logic was_busy;
    b = nfc_flash_model_inst.n_ev;
    start_op(8'h80, A2, 1'b0);
    wr_byte(8'h11, 1'b0);
    wr_byte(8'h22, 1'b1);
    wr_valid = 1'b0;
    wait_hi(busy, 1'b0, 2000);
    start_op(8'h10, A2, 1'b0);
    wait_hi(busy, 1'b0, 2000);
    chk_ev(b, 2'h0, 8'h80);
    chk_ev(b + 1, 2'h1, A2[7:0]);
    chk_ev(b + 4, 2'h2, 8'h11);
    chk_ev(b + 5, 2'h2, 8'h22);
    chk_ev(b + 6, 2'h0, 8'h10);
    // Status may go out while the flash is still programming
    nb = nfc_flash_model_inst.n_busy_cmd;
    was_busy = ~rb;
    start_op(8'h70, A2, 1'b0);
    rd_byte(8'hC0);
    rd_req = 1'b0;
    end_rd();
    `CHK(nfc_flash_model_inst.n_busy_cmd, nb + int'(was_busy))
    // A read offered while busy must be held back
    if (rb === 1'b0) begin
      op_code = 8'h00;
      op_addr = A2;
      op_valid = 1'b1;
      repeat (8) begin
        @(posedge clk);
        #1;
        `CHK(busy, 1'b0)
      end
    end
    t_read(8'h00, A2, 1'b0, 8'h11, 8'h22);
  endtask
  task automatic t_erase();
    int b;
    int nr;
    b = nfc_flash_model_inst.n_ev;
    nr = nfc_flash_model_inst.n_runs;
    start_op(8'h60, A1, 1'b0);
    wait_hi(busy, 1'b0, 2000);
    chk_ev(b, 2'h0, 8'h60);
    chk_ev(b + 1, 2'h1, A1[16:9]);
    chk_ev(b + 2, 2'h1, {2'b00, A1[22:17]});
    chk_ev(b + 3, 2'h0, 8'hD0);
    `CHK(nfc_flash_model_inst.n_runs, nr + 1)
  endtask
  task automatic t_short(input logic [7:0] c);
    int b;
    b = nfc_flash_model_inst.n_ev;
    start_op(c, 23'h0, 1'b0);
    end_rd();
    chk_ev(b, 2'h0, c);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    mismatches = 0;
    n_tests = 0;
    rst = 1'b1;
    op_valid = 1'b0;
    op_code = 8'h00;
    op_addr = 23'h0;
    op_spare = 1'b0;
    op_wp_n = 1'b1;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    wr_last = 1'b0;
    rd_req = 1'b0;
    op_end = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK(ce_n, 1'b1)
    `CHK(wp_n, 1'b0)
    `CHK(nfc_flash_model_inst.n_ev, 0)
    rst = 1'b0;
    t_read(8'h00, A1, 1'b0, pg(16), pg(17));
    t_read(8'h01, A1, 1'b0, pg(272), pg(273));
    t_read(8'h50, A1, 1'b1, pg(512), pg(513));
    t_prog();
    t_erase();
    t_short(8'h90);
    t_short(8'hFF);
    print_verdict();
  end
endmodule
